/* hw/sram_host.sv */
// host controller driving an asynchronous 8K x 24 static memory
// assumes a user request port on mclk and the memory wired to the pins
//
// Summary of operation
// RQ1: reads keep write strobe high throughout
// RQ2: store starts at latest select/strobe edge
// RQ3: store ends at first edge, data committed
// RQ4: write strobe high whenever address changes
// RQ5: strobe falling before select leaves pins undriven
// RQ6: never drive data while memory may drive
// RQ7: read address valid by select assertion
// RQ8: selected only when both selects asserted
// RQ9: multiplexer control changes count as address
// RQ10: multiplexer picks top bit or alternate bank
// RQ11: deasserted select means standby, no access
// RQ12: memory drives data only during reads
// RQ13: 8192 words of 24 bits addressed
`timescale 1ns/1ps
module sram_host
	import sram_host_pkg::*;
#(
	parameter int DW = DATA_W,
	parameter int AW = ADDR_W
)(
	// clock and reset
	input  wire logic          mclk,
	input  wire logic          reset_n,
	// request port
	input  wire logic          req_valid,
	output      logic          req_ready,
	input  wire logic          req_write,
	input  wire logic [AW-1:0] req_addr,
	input  wire logic          req_top_address_bit,
	input  wire logic          req_alt_bank,
	input  wire logic          req_mux_sel,
	input  wire logic [DW-1:0] req_wdata,
	// response port
	output      logic          rsp_valid,
	output      logic [DW-1:0] rsp_rdata,
	// memory pins
	output      logic [AW-1:0] mem_addr,
	output      logic          top_address_bit,
	output      logic          alt_bank,
	output      logic          mux_sel,
	output      logic          select_low_active,
	output      logic          select_high_active,
	output      logic          out_enable_n,
	output      logic          write_n,
	output      logic [DW-1:0] dq_o,
	output      logic          dq_oe,
	input  wire logic [DW-1:0] dq_i
);

	// ************************************************************
	// elaboration checks
	// ************************************************************
	// RQ13 array shape
	generate
		if (DW != DATA_W || AW != ADDR_W)
			$error("memory shape must be 8192 words of 24 bits");
	endgenerate

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		host_state_e      st;
		logic [CNT_W-1:0] cnt;
		logic             ready;
		logic             rsp;
		logic [DW-1:0]    rdata;
		logic [AW-1:0]    addr;
		logic             top;
		logic             alt;
		logic             msel;
		logic             sel_lo;
		logic             sel_hi;
		logic             oe_n;
		logic             we_n;
		logic [DW-1:0]    dout;
		logic             doe;
	} host_s;

	host_s s_q;
	host_s s_d;

	sram_rd_if #(.WIDTH(DW)) rd ();

	assign rd.pin_data = dq_i;

	sram_data_sync #(.WIDTH(DW)) u_sync (
		.mclk    (mclk),
		.reset_n (reset_n),
		.rd      (rd)
	);

	// cycle limits cut to the counter width
	localparam logic [CNT_W-1:0] WP_LAST   = CNT_W'(WP_CYC - 1);
	localparam logic [CNT_W-1:0] RD_LAST   = CNT_W'(ACC_CYC + SYNC_CYC - 1);
	localparam logic [CNT_W-1:0] TURN_LAST = CNT_W'(TURN_CYC - 1);

	// ************************************************************
	// sequencer
	// ************************************************************
	always_comb
	begin
		s_d     = s_q;
		s_d.rsp = 1'b0;
		s_d.cnt = s_q.cnt + CNT_W'(1);
		case (s_q.st)
			ST_IDLE:
			begin
				s_d.cnt = '0;
				if (req_valid && s_q.ready)
				begin
					// RQ9 address and mux set together
					s_d.addr   = req_addr;
					s_d.top    = req_top_address_bit;
					s_d.alt    = req_alt_bank;
					s_d.msel   = req_mux_sel;
					// RQ8 both selects asserted
					s_d.sel_lo = 1'b0;
					s_d.sel_hi = 1'b1;
					s_d.ready  = 1'b0;
					if (req_write)
					begin
						// RQ5 select before strobe
						s_d.st   = ST_WR_SETUP;
						s_d.dout = req_wdata;
						s_d.doe  = 1'b1;
					end
					else
					begin
						// RQ7 address with select
						s_d.st   = ST_RD_WAIT;
						// RQ1 strobe stays high on reads
						s_d.oe_n = 1'b0;
					end
				end
			end
			ST_WR_SETUP:
			begin
				// RQ2 strobe is the last start edge
				s_d.st   = ST_WR_PULSE;
				s_d.we_n = 1'b0;
				s_d.cnt  = '0;
			end
			ST_WR_PULSE:
				if (s_q.cnt == WP_LAST)
				begin
					// RQ3 strobe rise ends the store
					s_d.st   = ST_WR_HOLD;
					s_d.we_n = 1'b1;
				end
			ST_WR_HOLD:
			begin
				// RQ4 address moves only with strobe high
				s_d.st     = ST_IDLE;
				s_d.sel_lo = RST_SEL_LOW;
				s_d.sel_hi = RST_SEL_HIGH;
				s_d.doe    = 1'b0;
				s_d.ready  = 1'b1;
			end
			ST_RD_WAIT:
				if (s_q.cnt == RD_LAST)
				begin
					// RQ12 capture while output enabled
					s_d.st     = ST_RD_TURN;
					s_d.rdata  = rd.synced;
					s_d.rsp    = 1'b1;
					s_d.oe_n   = RST_STROBE;
					s_d.sel_lo = RST_SEL_LOW;
					s_d.sel_hi = RST_SEL_HIGH;
					s_d.cnt    = '0;
				end
			ST_RD_TURN:
				// RQ6 wait for memory to release bus
				if (s_q.cnt == TURN_LAST)
				begin
					s_d.st    = ST_IDLE;
					s_d.ready = 1'b1;
				end
			default:
				s_d.st = ST_IDLE;
		endcase
	end

	// register the state
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			s_q        <= '0;
			s_q.st     <= ST_IDLE;
			s_q.ready  <= 1'b1;
			s_q.sel_lo <= RST_SEL_LOW;
			s_q.sel_hi <= RST_SEL_HIGH;
			s_q.oe_n   <= RST_STROBE;
			s_q.we_n   <= RST_STROBE;
		end
		else
			s_q <= s_d;
	end

	// ************************************************************
	// outputs
	// ************************************************************
	// RQ10 both top-bit sources and the mux control
	assign top_address_bit    = s_q.top;
	assign alt_bank           = s_q.alt;
	assign mux_sel            = s_q.msel;
	assign req_ready          = s_q.ready;
	assign rsp_valid          = s_q.rsp;
	assign rsp_rdata          = s_q.rdata;
	assign mem_addr           = s_q.addr;
	assign select_low_active  = s_q.sel_lo;
	assign select_high_active = s_q.sel_hi;
	assign out_enable_n       = s_q.oe_n;
	assign write_n            = s_q.we_n;
	assign dq_o               = s_q.dout;
	assign dq_oe              = s_q.doe;

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	logic selected;
	assign selected = !s_q.sel_lo && s_q.sel_hi;

	sequence strobe_low_s;
		!s_q.we_n [*2];
	endsequence

	sequence strobe_end_s;
		s_q.we_n && s_q.doe && selected;
	endsequence

	read_strobe_high_a: assert property (!s_q.oe_n |-> s_q.we_n) // RQ1
		else $error("write strobe low during read");
	store_start_a: assert property ($fell(s_q.we_n) |-> selected && $past(selected)) // RQ2
		else $error("store started without select");
	store_end_a: assert property ($fell(s_q.we_n) |-> strobe_low_s ##1 strobe_end_s) // RQ3
		else $error("store not ended by strobe with data held");
	addr_steady_a: assert property (!$stable(s_q.addr) |-> s_q.we_n) // RQ4
		else $error("address changed while strobe low");
	strobe_after_sel_a: assert property ($rose(selected) && s_q.doe |-> // RQ5
		s_q.we_n ##1 (selected && !s_q.we_n))
		else $error("strobe fell together with select");
	no_contention_a: assert property (s_q.doe |-> s_q.oe_n) // RQ6
		else $error("data driven while memory output enabled");
	sel_addr_hold_a: assert property (selected && $past(selected) |-> // RQ9
		$stable(s_q.addr) && $stable(s_q.msel))
		else $error("address or mux moved inside an access");
	standby_idle_a: assert property (s_q.st == ST_IDLE |-> !selected && s_q.oe_n && s_q.we_n) // RQ11
		else $error("access outside a request");
	read_answer_a: assert property ($fell(s_q.oe_n) |-> ##6 s_q.rsp) // RQ12
		else $error("read answer not after six cycles");

endmodule // sram_host

/* hw/sram_host_pkg.sv */
// constants for the static memory host controller
// assumes a 100 MHz mclk and an asynchronous 8K x 24 memory on the pins
package sram_host_pkg;

	// ************************************************************
	// clock and pin timing
	// ************************************************************
	localparam int CLK_NS     = 10;  // mclk period
	localparam int T_WP_NS    = 20;  // least write strobe low time
	localparam int T_ACC_NS   = 35;  // longest read access time
	localparam int T_TURN_NS  = 15;  // longest data release after read
	localparam int SYNC_CYC   = 2;   // read data synchroniser depth
	// least times round up to whole cycles, never below one
	localparam int WP_CYC     = ((T_WP_NS + CLK_NS - 1) / CLK_NS) < 1 ? 1
	                          : ((T_WP_NS + CLK_NS - 1) / CLK_NS);
	localparam int ACC_CYC    = ((T_ACC_NS + CLK_NS - 1) / CLK_NS) < 1 ? 1
	                          : ((T_ACC_NS + CLK_NS - 1) / CLK_NS);
	localparam int TURN_CYC   = ((T_TURN_NS + CLK_NS - 1) / CLK_NS) < 1 ? 1
	                          : ((T_TURN_NS + CLK_NS - 1) / CLK_NS);

	// ************************************************************
	// widths and reset values
	// ************************************************************
	localparam int DATA_W     = 24;
	localparam int ADDR_W     = 12;  // direct address inputs
	localparam int CNT_W      = 4;
	localparam logic RST_SEL_LOW  = 1'b1; // low-active select idle
	localparam logic RST_SEL_HIGH = 1'b0; // high-active select idle
	localparam logic RST_STROBE   = 1'b1; // strobes idle high

	// ************************************************************
	// controller states
	// ************************************************************
	typedef enum logic [5:0] {
		ST_IDLE     = 6'h01,
		ST_WR_SETUP = 6'h02,
		ST_WR_PULSE = 6'h04,
		ST_WR_HOLD  = 6'h08,
		ST_RD_WAIT  = 6'h10,
		ST_RD_TURN  = 6'h20
	} host_state_e;

endpackage

/* hw/sram_rd_if.sv */
// carrier between the host controller and its read data synchroniser
// assumes both ends run on the same mclk
`timescale 1ns/1ps
interface sram_rd_if #(parameter int WIDTH = 24);
	logic [WIDTH-1:0] pin_data;  // raw data pins
	logic [WIDTH-1:0] synced;    // data after two flip-flops
	modport sync (input pin_data, output synced);
	modport host (output pin_data, input synced);
endinterface

/* hw/sram_data_sync.sv */
// two flip-flop synchroniser for the memory data pins
// assumes pin data is asynchronous to mclk and stable when sampled late
`timescale 1ns/1ps
module sram_data_sync
	import sram_host_pkg::*;
#(
	parameter int WIDTH = 24
)(
	// clock and reset
	input  wire logic mclk,
	input  wire logic reset_n,
	// data carrier
	sram_rd_if.sync   rd
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} sync_s;

	sync_s s_q;
	sync_s s_d;

	// first stage only feeds the second
	always_comb
	begin
		s_d        = s_q;
		s_d.meta   = rd.pin_data;
		s_d.stable = s_q.meta;
	end

	// register the state
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign rd.synced = s_q.stable;

endmodule // sram_data_sync

/* verification/sram_mem_model.sv */
// behavioural 8K x 24 static memory on the host pins
// assumes the bench resolves the shared data wire
`timescale 1ns/1ps
module sram_mem_model
#(
	parameter int ACC_NS = 30  // read data delay, may be raised
)(
	// address pins
	input  wire logic [11:0] mem_addr,
	input  wire logic        top_address_bit,
	input  wire logic        alt_bank,
	input  wire logic        mux_sel,
	// controls
	input  wire logic        select_low_active,
	input  wire logic        select_high_active,
	input  wire logic        out_enable_n,
	input  wire logic        write_n,
	// data
	input  wire logic [23:0] dq,
	output      logic [23:0] mem_q,
	output      logic        mem_oe
);
	logic [23:0] arr [0:8191];
	logic        wfirst = 1'b0;
	wire         sel = !select_low_active && select_high_active;
	wire  [12:0] idx = {mux_sel ? alt_bank : top_address_bit, mem_addr};
	wire         storing = sel && !write_n;
	always @(posedge sel) wfirst = !write_n;
	always @(negedge storing) arr[idx] = dq;
	assign mem_oe = sel && !out_enable_n && write_n && !wfirst;
	assign #(ACC_NS) mem_q = arr[idx];
endmodule // sram_mem_model

/* verification/async_sram_addr_mux_tb.sv */
// self-checking bench for the static memory host controller
// assumes sram_mem_model on the pins and a 100 MHz mclk
`timescale 1ns/1ps
module async_sram_addr_mux_tb
	import sram_host_pkg::*;
;
	logic        mclk = 1'b0;
	logic        reset_n = 1'b0;
	logic        req_valid = 1'b0;
	logic        req_write = 1'b0;
	logic [11:0] req_addr = 12'h000;
	logic        req_top_address_bit = 1'b0;
	logic        req_alt_bank = 1'b0;
	logic        req_mux_sel = 1'b0;
	logic [23:0] req_wdata = 24'h000000;
	logic        req_ready, rsp_valid, top_address_bit, alt_bank, mux_sel;
	logic        select_low_active, select_high_active, out_enable_n, write_n;
	logic        dq_oe, mem_oe, prev_wn;
	logic [11:0] mem_addr;
	logic [14:0] prev_pins;
	logic [23:0] rsp_rdata, dq_o, dq_i, mem_q, last_q;
	logic [23:0] exp_mem [0:8191];
	int          err_count = 0;
	int          n_checks = 0;
	wire  [14:0] pins = {top_address_bit, alt_bank, mux_sel, mem_addr};

	always #5 mclk = ~mclk;

	// shared data wire, released lines show the inverse of last value
	assign dq_i = dq_oe ? dq_o : (mem_oe === 1'b1 ? mem_q : ~last_q);
	always @(posedge mclk) last_q <= dq_i;

	sram_host u_dut (.mclk, .reset_n, .req_valid, .req_ready, .req_write, .req_addr,
		.req_top_address_bit, .req_alt_bank, .req_mux_sel, .req_wdata, .rsp_valid,
		.rsp_rdata, .mem_addr, .top_address_bit, .alt_bank, .mux_sel, .select_low_active,
		.select_high_active, .out_enable_n, .write_n, .dq_o, .dq_oe, .dq_i);

	sram_mem_model u_mem (.mem_addr, .top_address_bit, .alt_bank, .mux_sel,
		.select_low_active, .select_high_active, .out_enable_n, .write_n, .dq(dq_i),
		.mem_q, .mem_oe);

	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		$display("checks=%0d errors=%0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// reset for four cycles and look at the idle pins
	task automatic do_reset();
		@(posedge mclk);
		reset_n <= 1'b0;
		repeat (4) @(posedge mclk);
		check({17'h0, select_low_active, select_high_active, out_enable_n, write_n, dq_oe,
			req_ready, rsp_valid}, 24'h00005A);
		reset_n <= 1'b1;
	endtask

	// one request; tam is top bit, alt bank, mux control
	task automatic op(input logic wr, input logic [11:0] a, input logic [2:0] tam,
		input logic [23:0] d, input logic ghost);
		int          n_rdy;
		int          n_rsp;
		logic [23:0] rd;
		logic [12:0] idx;
		n_rdy = 0;
		n_rsp = 0;
		rd = 24'h000000;
		idx = {tam[0] ? tam[1] : tam[2], a};
		@(posedge mclk);
		req_valid <= 1'b1;
		{req_write, req_addr, req_top_address_bit, req_alt_bank, req_mux_sel} <= {wr, a, tam};
		req_wdata <= d;
		@(posedge mclk);
		req_valid <= 1'b0;
		for (int i = 1; i <= 20 && n_rdy == 0; i++)
		begin
			@(posedge mclk);
			req_valid <= ghost && i == 2;
			#1;
			if (rsp_valid === 1'b1)
			begin
				n_rsp = i;
				rd = rsp_rdata;
			end
			if (req_ready === 1'b1)
				n_rdy = i;
		end
		if (n_rdy == 0)
		begin
			err_count++;
			summarize();
		end
		// edges counted from the take edge, where the pins already move
		if (wr)
		begin
			check(24'(n_rdy), 24'h000004);
			exp_mem[idx] = d;
		end
		else
		begin
			check(24'(n_rsp), 24'h000006);
			check(24'(n_rdy), 24'h000008);
			check(rd, exp_mem[idx]);
		end
		// a request refused while busy must not start an access later
		if (ghost)
		begin
			@(posedge mclk);
			#1;
			check({23'h0, select_low_active}, 24'h000001);
		end
	endtask

	// pin protocol watch on the falling edge
	always @(negedge mclk)
	begin
		if (reset_n)
		begin
			if (write_n === 1'b0 && prev_wn === 1'b0)
				check({9'h0, pins}, {9'h0, prev_pins});
			check({22'h0, !write_n && !out_enable_n, dq_oe && mem_oe}, 24'h0);
		end
		prev_pins <= pins;
		prev_wn <= write_n;
	end

	// watchdog
	initial
	begin
		repeat (5000) @(posedge mclk);
		err_count++;
		summarize();
	end

	// ************************************************************
	// main sequence
	// ************************************************************
	initial
	begin
		do_reset();
		op(1'b1, 12'h000, 3'b100, 24'hA5A5A5, 1'b0);
		op(1'b1, 12'hFFF, 3'b011, 24'h123456, 1'b0);
		op(1'b1, 12'hFFF, 3'b000, 24'hFEDCBA, 1'b0);
		op(1'b0, 12'h000, 3'b011, 24'h000000, 1'b0);
		op(1'b0, 12'hFFF, 3'b100, 24'h000000, 1'b0);
		op(1'b0, 12'hFFF, 3'b110, 24'h000000, 1'b0);
		op(1'b0, 12'hFFF, 3'b001, 24'h000000, 1'b1);
		do_reset();
		op(1'b0, 12'hFFF, 3'b000, 24'h000000, 1'b0);
		op(1'b1, 12'hFFF, 3'b001, 24'h000000, 1'b0);
		op(1'b0, 12'hFFF, 3'b000, 24'h000000, 1'b0);
		op(1'b0, 12'h000, 3'b100, 24'h000000, 1'b1);
		summarize();
	end
endmodule // async_sram_addr_mux_tb
